// [verilog/ceau_pkg.sv]
`default_nettype none
package ceau_pkg;

  // Addressing mode selected by the decoder
  typedef enum logic [3:0] {
    ceau_am_reg_direct,
    ceau_am_reg_indirect,
    ceau_am_reg_disp,
    ceau_am_post_inc,
    ceau_am_pre_dec,
    ceau_am_abs8,
    ceau_am_abs16,
    ceau_am_immediate,
    ceau_am_pc_rel,
    ceau_am_mem_indirect
  } ceau_mode_e;

  // Instruction class presented with each request
  typedef enum logic [4:0] {
    ceau_ic_byte_move,
    ceau_ic_word_move,
    ceau_ic_word_add,
    ceau_ic_word_subtract,
    ceau_ic_word_compare,
    ceau_ic_address_add,
    ceau_ic_address_subtract,
    ceau_ic_unsigned_multiply,
    ceau_ic_unsigned_divide,
    ceau_ic_byte_add,
    ceau_ic_add_with_carry,
    ceau_ic_subtract_with_carry,
    ceau_ic_byte_compare,
    ceau_ic_logic_and,
    ceau_ic_logic_or,
    ceau_ic_logic_xor,
    ceau_ic_other_alu,
    ceau_ic_jump,
    ceau_ic_subroutine_jump,
    ceau_ic_conditional_branch,
    ceau_ic_branch_to_subroutine,
    ceau_ic_bit_set,
    ceau_ic_bit_clear,
    ceau_ic_bit_invert,
    ceau_ic_bit_test,
    ceau_ic_other_bit
  } ceau_class_e;

  localparam logic [7:0] ABS8_UPPER = 8'hFF;
  localparam logic [7:0] MEM_IND_UPPER = 8'h00;
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] IMPLIED_ONE = 16'h0001;
  localparam logic [15:0] IMPLIED_TWO = 16'h0002;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam int BIT_NUM_LSB = 4;
  localparam logic [2:0] BIT_NUM_RESET = 3'h0;
  localparam logic [3:0] REG_INDEX_RESET = 4'h0;

endpackage
`default_nettype wire

// [verilog/ceau_addr_add.sv]
`timescale 1ns/10ps
`default_nettype none
module ceau_addr_add (
  input wire logic [15:0] base,
  input wire logic [15:0] offset,
  input wire logic force_even,
  output logic [15:0] sum
);

  logic [15:0] raw;

  assign raw = base + offset;
  assign sum = {raw[15:1], raw[0] & ~force_even};

endmodule
`default_nettype wire

// [verilog/ceau_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ceau_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire ceau_pkg::ceau_mode_e req_mode,
  input wire ceau_pkg::ceau_class_e req_class,
  input wire logic req_is_store,
  input wire logic [3:0] req_reg_field,
  input wire logic [7:0] req_byte2,
  input wire logic [7:0] req_byte3,
  input wire logic [7:0] req_byte4,
  input wire logic req_implied_two,
  input wire logic req_bit_from_reg,
  input wire logic req_bit_in_byte4,
  input wire logic [7:0] bit_reg_value,
  input wire logic [15:0] reg_value,
  input wire logic [15:0] pc_value,
  input wire logic mem_rd_ack,
  input wire logic [15:0] mem_rd_data,
  output logic busy,
  output logic done,
  output logic fault,
  output logic [15:0] ea_addr,
  output logic ea_is_mem,
  output logic [15:0] imm_data,
  output logic imm_valid,
  output logic opnd_reg_valid,
  output logic opnd_reg_wide,
  output logic [3:0] opnd_reg_index,
  output logic wb_valid,
  output logic [2:0] wb_index,
  output logic [15:0] wb_value,
  output logic bit_valid,
  output logic [2:0] bit_number,
  output logic mem_rd_req,
  output logic [15:0] mem_rd_addr
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {
    ceau_st_idle,
    ceau_st_fetch_ptr
  } ceau_state_e;

  typedef struct packed {
    ceau_state_e state;
    logic done;
    logic fault;
    logic [15:0] ea;
    logic ea_is_mem;
    logic [15:0] imm;
    logic imm_valid;
    logic reg_valid;
    logic reg_wide;
    logic [3:0] reg_index;
    logic wb_valid;
    logic [2:0] wb_index;
    logic [15:0] wb_value;
    logic bit_valid;
    logic [2:0] bit_number;
    logic rd_req;
    logic [15:0] rd_addr;
  } ceau_regs_s;

  localparam ceau_regs_s REGS_RESET = '{
    state: ceau_st_idle,
    done: 1'b0,
    fault: 1'b0,
    ea: ceau_pkg::ZERO_WORD,
    ea_is_mem: 1'b0,
    imm: ceau_pkg::ZERO_WORD,
    imm_valid: 1'b0,
    reg_valid: 1'b0,
    reg_wide: 1'b0,
    reg_index: ceau_pkg::REG_INDEX_RESET,
    wb_valid: 1'b0,
    wb_index: ceau_pkg::BIT_NUM_RESET,
    wb_value: ceau_pkg::ZERO_WORD,
    bit_valid: 1'b0,
    bit_number: ceau_pkg::BIT_NUM_RESET,
    rd_req: 1'b0,
    rd_addr: ceau_pkg::ZERO_WORD
  };

  ceau_regs_s regs_reg;
  ceau_regs_s regs_next;

  ////////////////////////////////////////////////////////////////////////////
  // Class groups
  logic cls_move;
  logic cls_word_move;
  logic cls_bit;
  logic cls_bit_reg_ok;
  logic cls_wide;
  logic cls_alu;
  logic cls_alu_imm;
  logic cls_addr_step;
  logic cls_jump;
  logic cls_rel;
  logic mode_ok;

  assign cls_word_move = (req_class == ceau_pkg::ceau_ic_word_move);
  assign cls_move = cls_word_move || (req_class == ceau_pkg::ceau_ic_byte_move);
  assign cls_addr_step = (req_class == ceau_pkg::ceau_ic_address_add) ||
                         (req_class == ceau_pkg::ceau_ic_address_subtract);
  assign cls_jump = (req_class == ceau_pkg::ceau_ic_jump) ||
                    (req_class == ceau_pkg::ceau_ic_subroutine_jump);
  assign cls_rel = (req_class == ceau_pkg::ceau_ic_conditional_branch) ||
                   (req_class == ceau_pkg::ceau_ic_branch_to_subroutine);
  assign cls_bit_reg_ok = (req_class == ceau_pkg::ceau_ic_bit_set) ||
                          (req_class == ceau_pkg::ceau_ic_bit_clear) ||
                          (req_class == ceau_pkg::ceau_ic_bit_invert) ||
                          (req_class == ceau_pkg::ceau_ic_bit_test);
  assign cls_bit = cls_bit_reg_ok || (req_class == ceau_pkg::ceau_ic_other_bit);
  assign cls_wide = cls_word_move || cls_addr_step ||
                    (req_class == ceau_pkg::ceau_ic_word_add) ||
                    (req_class == ceau_pkg::ceau_ic_word_subtract) ||
                    (req_class == ceau_pkg::ceau_ic_word_compare) ||
                    (req_class == ceau_pkg::ceau_ic_unsigned_multiply) ||
                    (req_class == ceau_pkg::ceau_ic_unsigned_divide);
  assign cls_alu_imm = (req_class == ceau_pkg::ceau_ic_byte_add) ||
                       (req_class == ceau_pkg::ceau_ic_add_with_carry) ||
                       (req_class == ceau_pkg::ceau_ic_subtract_with_carry) ||
                       (req_class == ceau_pkg::ceau_ic_byte_compare) ||
                       (req_class == ceau_pkg::ceau_ic_logic_and) ||
                       (req_class == ceau_pkg::ceau_ic_logic_or) ||
                       (req_class == ceau_pkg::ceau_ic_logic_xor);
  assign cls_alu = cls_alu_imm || cls_wide || (req_class == ceau_pkg::ceau_ic_other_alu);

  ////////////////////////////////////////////////////////////////////////////
  // Mode permission per class
  always_comb begin
    mode_ok = 1'b0;
    unique case (req_mode)
      ceau_pkg::ceau_am_reg_direct: begin
        mode_ok = cls_alu || cls_move || cls_bit;
      end
      ceau_pkg::ceau_am_reg_indirect: begin
        mode_ok = cls_move || cls_bit || cls_jump;
      end
      ceau_pkg::ceau_am_reg_disp: begin
        mode_ok = cls_move;
      end
      ceau_pkg::ceau_am_post_inc: begin
        mode_ok = cls_move && !req_is_store;
      end
      ceau_pkg::ceau_am_pre_dec: begin
        mode_ok = cls_move && req_is_store;
      end
      ceau_pkg::ceau_am_abs8: begin
        mode_ok = (req_class == ceau_pkg::ceau_ic_byte_move) || cls_bit;
      end
      ceau_pkg::ceau_am_abs16: begin
        mode_ok = cls_move || cls_jump;
      end
      ceau_pkg::ceau_am_immediate: begin
        mode_ok = cls_move || cls_alu_imm;
      end
      ceau_pkg::ceau_am_pc_rel: begin
        mode_ok = cls_rel;
      end
      ceau_pkg::ceau_am_mem_indirect: begin
        mode_ok = cls_jump;
      end
      default: begin
        mode_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address arithmetic
  logic [15:0] step;
  logic [15:0] step_neg;
  logic [15:0] ea_base;
  logic [15:0] ea_offset;
  logic ea_even;
  logic [15:0] ea_sum;
  logic [15:0] upd_offset;
  logic [15:0] upd_sum;

  assign step = cls_word_move ? ceau_pkg::STEP_WORD : ceau_pkg::STEP_BYTE;
  assign step_neg = ceau_pkg::ZERO_WORD - step;

  always_comb begin
    ea_base = reg_value;
    ea_offset = ceau_pkg::ZERO_WORD;
    ea_even = cls_word_move;
    upd_offset = ceau_pkg::ZERO_WORD;
    unique case (req_mode)
      ceau_pkg::ceau_am_reg_disp: begin
        ea_offset = {req_byte3, req_byte4};
      end
      ceau_pkg::ceau_am_post_inc: begin
        upd_offset = step;
      end
      ceau_pkg::ceau_am_pre_dec: begin
        ea_offset = step_neg;
        upd_offset = step_neg;
      end
      ceau_pkg::ceau_am_abs8: begin
        ea_base = {ceau_pkg::ABS8_UPPER, req_byte2};
      end
      ceau_pkg::ceau_am_abs16: begin
        ea_base = {req_byte3, req_byte4};
        ea_even = cls_word_move || cls_jump;
      end
      ceau_pkg::ceau_am_pc_rel: begin
        ea_base = pc_value;
        ea_offset = {{8{req_byte2[7]}}, req_byte2};
        ea_even = 1'b1;
      end
      ceau_pkg::ceau_am_reg_indirect: begin
        ea_even = cls_word_move || cls_jump;
      end
      default: begin
        ea_base = reg_value;
      end
    endcase
  end

  ceau_addr_add u_ea_add (
    .base(ea_base),
    .offset(ea_offset),
    .force_even(ea_even),
    .sum(ea_sum)
  );

  ceau_addr_add u_upd_add (
    .base(reg_value),
    .offset(upd_offset),
    .force_even(1'b0),
    .sum(upd_sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Operand details
  logic [15:0] imm_word;
  logic [2:0] imm_bit;
  logic bit_src_bad;

  assign imm_word = cls_word_move ? {req_byte3, req_byte4} : {8'h00, req_byte2};
  assign imm_bit = req_bit_in_byte4 ?
                   req_byte4[ceau_pkg::BIT_NUM_LSB +: 3] :
                   req_byte2[ceau_pkg::BIT_NUM_LSB +: 3];
  assign bit_src_bad = cls_bit && req_bit_from_reg && !cls_bit_reg_ok;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    regs_next = regs_reg;
    regs_next.done = 1'b0;
    regs_next.fault = 1'b0;
    regs_next.wb_valid = 1'b0;
    unique case (regs_reg.state)
      ceau_st_idle: begin
        if (req_valid) begin
          regs_next.fault = !mode_ok || bit_src_bad;
          regs_next.ea = ea_sum;
          regs_next.ea_is_mem = !((req_mode == ceau_pkg::ceau_am_reg_direct) ||
                                  (req_mode == ceau_pkg::ceau_am_immediate));
          regs_next.imm_valid = 1'b0;
          regs_next.imm = ceau_pkg::ZERO_WORD;
          if (cls_addr_step) begin
            regs_next.imm_valid = 1'b1;
            regs_next.imm = req_implied_two ? ceau_pkg::IMPLIED_TWO : ceau_pkg::IMPLIED_ONE;
          end else if (req_mode == ceau_pkg::ceau_am_immediate) begin
            regs_next.imm_valid = 1'b1;
            regs_next.imm = imm_word;
          end
          regs_next.reg_valid = (req_mode == ceau_pkg::ceau_am_reg_direct);
          regs_next.reg_wide = cls_wide;
          regs_next.reg_index = req_reg_field;
          if (req_mode != ceau_pkg::ceau_am_reg_direct) begin
            regs_next.reg_wide = 1'b1;
          end
          regs_next.wb_index = req_reg_field[2:0];
          regs_next.wb_value = upd_sum;
          regs_next.bit_valid = cls_bit;
          regs_next.bit_number = req_bit_from_reg ? bit_reg_value[2:0] : imm_bit;
          if (mode_ok && !bit_src_bad) begin
            regs_next.wb_valid = (req_mode == ceau_pkg::ceau_am_post_inc) ||
                                 (req_mode == ceau_pkg::ceau_am_pre_dec);
            if (req_mode == ceau_pkg::ceau_am_mem_indirect) begin
              regs_next.rd_req = 1'b1;
              regs_next.rd_addr = {ceau_pkg::MEM_IND_UPPER, req_byte2[7:1], 1'b0};
              regs_next.state = ceau_st_fetch_ptr;
            end else begin
              regs_next.done = 1'b1;
            end
          end else begin
            regs_next.done = 1'b1;
          end
        end
      end
      ceau_st_fetch_ptr: begin
        if (mem_rd_ack) begin
          regs_next.rd_req = 1'b0;
          regs_next.ea = {mem_rd_data[15:1], 1'b0};
          regs_next.done = 1'b1;
          regs_next.state = ceau_st_idle;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      regs_reg <= REGS_RESET;
    end else begin
      regs_reg <= regs_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign busy = (regs_reg.state == ceau_st_fetch_ptr);
  assign done = regs_reg.done;
  assign fault = regs_reg.fault;
  assign ea_addr = regs_reg.ea;
  assign ea_is_mem = regs_reg.ea_is_mem;
  assign imm_data = regs_reg.imm;
  assign imm_valid = regs_reg.imm_valid;
  assign opnd_reg_valid = regs_reg.reg_valid;
  assign opnd_reg_wide = regs_reg.reg_wide;
  assign opnd_reg_index = regs_reg.reg_index;
  assign wb_valid = regs_reg.wb_valid;
  assign wb_index = regs_reg.wb_index;
  assign wb_value = regs_reg.wb_value;
  assign bit_valid = regs_reg.bit_valid;
  assign bit_number = regs_reg.bit_number;
  assign mem_rd_req = regs_reg.rd_req;
  assign mem_rd_addr = regs_reg.rd_addr;

endmodule
`default_nettype wire

// [dv/ceau_checker.sv]
`timescale 1ns/10ps
`default_nettype none
module ceau_checker (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  input wire ceau_pkg::ceau_mode_e req_mode,
  input wire ceau_pkg::ceau_class_e req_class,
  input wire logic req_is_store,
  input wire logic [7:0] req_byte2,
  input wire logic [7:0] req_byte3,
  input wire logic [7:0] req_byte4,
  input wire logic [15:0] reg_value,
  input wire logic [15:0] pc_value,
  input wire logic mem_rd_ack,
  input wire logic [15:0] mem_rd_data,
  input wire logic busy,
  input wire logic done,
  input wire logic fault,
  input wire logic [15:0] ea_addr,
  input wire logic wb_valid,
  input wire logic [15:0] wb_value,
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic tk;
  logic bm;
  assign tk = req_valid && !busy;
  assign bm = req_class == ceau_pkg::ceau_ic_byte_move;
  ////////////////////////////////////////////////////////////////
  abs8_upper_a: assert property (
    tk && req_mode == ceau_pkg::ceau_am_abs8 |=> ea_addr == {8'hFF, $past(req_byte2)})
    else $error("short absolute address wrong");
  ind_plain_a: assert property (
    tk && bm && req_mode == ceau_pkg::ceau_am_reg_indirect |=> ea_addr == $past(reg_value))
    else $error("indirect address wrong");
  disp_sum_a: assert property (
    tk && bm && req_mode == ceau_pkg::ceau_am_reg_disp
    |=> ea_addr == $past(reg_value) + {$past(req_byte3), $past(req_byte4)})
    else $error("displacement address wrong");
  post_inc_a: assert property (
    tk && bm && !req_is_store && req_mode == ceau_pkg::ceau_am_post_inc
    |=> wb_valid && ea_addr == $past(reg_value) && wb_value == $past(reg_value) + 16'h0001)
    else $error("post increment wrong");
  pre_dec_a: assert property (
    tk && bm && req_is_store && req_mode == ceau_pkg::ceau_am_pre_dec
    |=> wb_valid && ea_addr == wb_value && wb_value == $past(reg_value) - 16'h0001)
    else $error("pre decrement wrong");
  pc_rel_a: assert property (
    tk && req_mode == ceau_pkg::ceau_am_pc_rel
    && req_class == ceau_pkg::ceau_ic_conditional_branch
    |=> ea_addr == (($past(pc_value) + {{8{$past(req_byte2[7])}}, $past(req_byte2)}) & 16'hFFFE))
    else $error("branch destination wrong");
  word_even_a: assert property (
    tk && req_class == ceau_pkg::ceau_ic_word_move && req_mode != ceau_pkg::ceau_am_reg_direct
    && req_mode != ceau_pkg::ceau_am_immediate && req_mode != ceau_pkg::ceau_am_abs8
    |=> !ea_addr[0]) else $error("word address odd");
  ptr_read_a: assert property (
    tk && req_mode == ceau_pkg::ceau_am_mem_indirect && req_class == ceau_pkg::ceau_ic_jump
    |=> mem_rd_req && busy && !done && mem_rd_addr[15:8] == 8'h00)
    else $error("pointer read missing");
  ptr_done_a: assert property (
    mem_rd_req && mem_rd_ack
    |=> done && !mem_rd_req && ea_addr == ($past(mem_rd_data) & 16'hFFFE))
    else $error("pointer destination wrong");
  bit_mode_a: assert property (
    tk && req_class == ceau_pkg::ceau_ic_bit_set && req_mode == ceau_pkg::ceau_am_reg_disp
    |=> done && fault && !wb_valid) else $error("bit operand mode not refused");
  cover property (mem_rd_req && mem_rd_ack);
  cover property (done && fault);
  cover property (wb_valid);
endmodule
bind ceau_top ceau_checker u_chk (.*);
`default_nettype wire

// [dv/ceau_mem_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ceau_mem_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic mem_rd_req,
  input wire logic [15:0] mem_rd_addr,
  output logic mem_rd_ack,
  output logic [15:0] mem_rd_data
);
  logic [3:0] cnt;
  // Data lines toggle while no read is requested
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_rd_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rd_data <= 16'h5A5A;
    end else if (!mem_rd_req || mem_rd_ack) begin
      mem_rd_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rd_data <= ~mem_rd_data;
    end else if (cnt >= (slow ? 4'h6 : 4'h0)) begin
      mem_rd_ack <= 1'b1;
      mem_rd_data <= {mem_rd_addr[7:0], 8'h35};
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0, req_is_store = 1'b0, req_implied_two = 1'b0, slow = 1'b0;
  logic req_bit_from_reg = 1'b0, req_bit_in_byte4 = 1'b0;
  ceau_pkg::ceau_mode_e req_mode = ceau_pkg::ceau_am_reg_direct;
  ceau_pkg::ceau_class_e req_class = ceau_pkg::ceau_ic_byte_move;
  logic [3:0] req_reg_field = 4'h5;
  logic [7:0] req_byte2 = 8'h00, req_byte3 = 8'h00, req_byte4 = 8'h00, bit_reg_value = 8'h07;
  logic [15:0] reg_value = 16'h0000, pc_value = 16'h1000;
  logic [15:0] mem_rd_data, ea_addr, imm_data, wb_value, mem_rd_addr;
  logic mem_rd_ack, busy, done, fault, ea_is_mem, imm_valid, opnd_reg_valid, opnd_reg_wide;
  logic wb_valid, bit_valid, mem_rd_req;
  logic [3:0] opnd_reg_index;
  logic [2:0] wb_index, bit_number;
  int err_total = 0;
  int tests_run = 0;

  ceau_top u_dut (.*);
  ceau_mem_model u_mem (.*);

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // One request, then wait for its done pulse
  task automatic go(input ceau_pkg::ceau_mode_e m, input ceau_pkg::ceau_class_e c,
                    input logic [15:0] r = 16'h0, input logic [7:0] b2 = 8'h0,
                    input logic [15:0] w = 16'h0);
    int n;
    @(negedge ref_clk);
    req_mode = m;
    req_class = c;
    reg_value = r;
    req_byte2 = b2;
    {req_byte3, req_byte4} = w;
    req_valid = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    // Done is a single cycle pulse, so look before waiting another edge
    while (done !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk("done", 16'(done), 16'h0001);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_addr;
    go(ceau_pkg::ceau_am_reg_indirect, ceau_pkg::ceau_ic_byte_move, 16'h1235);
    chk("ind_ea", ea_addr, 16'h1235);
    go(ceau_pkg::ceau_am_reg_direct, ceau_pkg::ceau_ic_word_add);
    chk("reg_wide", 16'({opnd_reg_valid, opnd_reg_wide, ea_is_mem}), 16'h0006);
    chk("reg_idx", 16'(opnd_reg_index), 16'h0005);
    go(ceau_pkg::ceau_am_reg_disp, ceau_pkg::ceau_ic_byte_move, 16'hFFF0, 8'h0, 16'h0020);
    chk("disp_wrap", ea_addr, 16'h0010);
    go(ceau_pkg::ceau_am_reg_disp, ceau_pkg::ceau_ic_word_move, 16'h1000, 8'h0, 16'h0003);
    chk("disp_even", ea_addr, 16'h1002);
    go(ceau_pkg::ceau_am_reg_disp, ceau_pkg::ceau_ic_bit_set);
    chk("bit_disp", 16'(fault), 16'h0001);
    go(ceau_pkg::ceau_am_abs8, ceau_pkg::ceau_ic_bit_clear, 16'h0, 8'h34);
    chk("abs8", {ea_addr[15:1], fault}, 16'hFF34);
    go(ceau_pkg::ceau_am_abs8, ceau_pkg::ceau_ic_word_move);
    chk("abs8_word", 16'(fault), 16'h0001);
    go(ceau_pkg::ceau_am_abs16, ceau_pkg::ceau_ic_jump, 16'h0, 8'h0, 16'h1235);
    chk("abs16", ea_addr, 16'h1234);
    go(ceau_pkg::ceau_am_abs16, ceau_pkg::ceau_ic_word_add);
    chk("abs16_alu", 16'(fault), 16'h0001);
  endtask

  task automatic t_step;
    go(ceau_pkg::ceau_am_post_inc, ceau_pkg::ceau_ic_word_move, 16'hFFFE);
    chk("inc_ea", ea_addr, 16'hFFFE);
    chk("inc_wb", wb_value, 16'h0000);
    chk("inc_idx", 16'(wb_index), 16'h0005);
    go(ceau_pkg::ceau_am_post_inc, ceau_pkg::ceau_ic_byte_move, 16'h00FF);
    chk("inc_byte_ea", ea_addr, 16'h00FF);
    chk("inc_byte_wb", wb_value, 16'h0100);
    req_is_store = 1'b1;
    go(ceau_pkg::ceau_am_pre_dec, ceau_pkg::ceau_ic_byte_move, 16'h0000);
    chk("dec_byte", ea_addr, 16'hFFFF);
    go(ceau_pkg::ceau_am_pre_dec, ceau_pkg::ceau_ic_word_move, 16'h2000);
    chk("dec_word", {wb_value[15:1], wb_valid}, 16'h1FFF);
    req_is_store = 1'b0;
  endtask

  task automatic t_imm;
    go(ceau_pkg::ceau_am_immediate, ceau_pkg::ceau_ic_byte_add, 16'h0, 8'h5A);
    chk("imm8", {imm_data[15:1], imm_valid}, 16'h005B);
    go(ceau_pkg::ceau_am_immediate, ceau_pkg::ceau_ic_word_move, 16'h0, 8'h0, 16'hBEEF);
    chk("imm16", imm_data, 16'hBEEF);
    go(ceau_pkg::ceau_am_immediate, ceau_pkg::ceau_ic_word_add);
    chk("imm_alu", 16'(fault), 16'h0001);
    req_implied_two = 1'b1;
    go(ceau_pkg::ceau_am_reg_direct, ceau_pkg::ceau_ic_address_add);
    chk("impl_two", imm_data, 16'h0002);
    req_implied_two = 1'b0;
    go(ceau_pkg::ceau_am_reg_direct, ceau_pkg::ceau_ic_address_subtract);
    chk("impl_one", imm_data, 16'h0001);
    req_bit_in_byte4 = 1'b1;
    go(ceau_pkg::ceau_am_reg_direct, ceau_pkg::ceau_ic_bit_test, 16'h0, 8'h0, 16'h0050);
    chk("bit_imm", 16'({bit_valid, bit_number}), 16'h000D);
    req_bit_from_reg = 1'b1;
    go(ceau_pkg::ceau_am_reg_indirect, ceau_pkg::ceau_ic_bit_invert);
    chk("bit_reg", 16'({fault, bit_number}), 16'h0007);
    go(ceau_pkg::ceau_am_reg_direct, ceau_pkg::ceau_ic_other_bit);
    chk("bit_reg_bad", 16'(fault), 16'h0001);
    req_bit_from_reg = 1'b0;
    req_bit_in_byte4 = 1'b0;
    go(ceau_pkg::ceau_am_pc_rel, ceau_pkg::ceau_ic_byte_move);
    chk("move_rel", 16'(fault), 16'h0001);
  endtask

  task automatic t_branch;
    go(ceau_pkg::ceau_am_pc_rel, ceau_pkg::ceau_ic_conditional_branch, 16'h0, 8'h80);
    chk("br_back", ea_addr, 16'h0F80);
    go(ceau_pkg::ceau_am_pc_rel, ceau_pkg::ceau_ic_branch_to_subroutine, 16'h0, 8'h7F);
    chk("br_odd", ea_addr, 16'h107E);
  endtask

  task automatic t_ind;
    slow = 1'b1;
    fork
      go(ceau_pkg::ceau_am_mem_indirect, ceau_pkg::ceau_ic_jump, 16'h0, 8'h41);
      begin
        repeat (3) @(negedge ref_clk);
        chk("ptr_addr", mem_rd_addr, 16'h0040);
        chk("ptr_busy", 16'(busy), 16'h0001);
        req_mode = ceau_pkg::ceau_am_abs8;
        req_byte2 = 8'h11;
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
      end
    join
    chk("ptr_dest", ea_addr, 16'h4034);
    slow = 1'b0;
    go(ceau_pkg::ceau_am_mem_indirect, ceau_pkg::ceau_ic_subroutine_jump, 16'h0, 8'hFF);
    chk("ptr_top", ea_addr, 16'hFE34);
    go(ceau_pkg::ceau_am_mem_indirect, ceau_pkg::ceau_ic_byte_move);
    chk("move_ind", 16'({fault, mem_rd_req}), 16'h0002);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge ref_clk);
    reset = 1'b0;
    t_addr();
    t_step();
    t_imm();
    t_branch();
    t_ind();
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
